// File: src/qpu_regs.vh
// qpu_regs.vh: register addresses, field positions and reset values for
// the quad pointer unit; assumes an 8-bit special register port.
//
// What this block does
// - four independent 24-bit pointers, each byte readable and writable
// - two-bit select code picks active pointer 0 through 3
// - upper select at bit 3, lower at bit 0; instructions use active one
// - bits beside lower select unimplemented; increment flips lower select
// - per-pointer direction bit: clear counts up, set counts down
// - directions 0/1 at select bits 6/7, 2/3 at second register 6/7
// - toggle enable at bit 5 flips lower select after listed ops
// - toggling never changes upper select; alternates within the pair
// - auto-step bit 4 steps active pointer after table and external moves
// - update the pointer that was active, then switch selection
// - pointer 0 sits at the legacy pointer addresses
`ifndef QPU_REGS_VH
`define QPU_REGS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define QPU_PTR0_LOW_ADDR 8'h82
`define QPU_PTR0_MID_ADDR 8'h83
`define QPU_PTR1_LOW_ADDR 8'h84
`define QPU_PTR1_MID_ADDR 8'h85
`define QPU_PTR0_HIGH_ADDR 8'h93
`define QPU_PTR1_HIGH_ADDR 8'h95
`define QPU_PTR2_HIGH_ADDR 8'heb
`define QPU_PTR3_HIGH_ADDR 8'hed
`define QPU_PTR2_LOW_ADDR 8'hf2
`define QPU_PTR2_MID_ADDR 8'hf3
`define QPU_PTR3_LOW_ADDR 8'hf4
`define QPU_PTR3_MID_ADDR 8'hf5
// select and upper direction addresses sit in otherwise unused slots
`define QPU_SELECT_ADDR 8'h86
`define QPU_DIR_UPPER_ADDR 8'he3

// ----------------------------------------
// field positions
// ----------------------------------------
`define QPU_LOWER_SEL_BIT 0
`define QPU_UPPER_SEL_BIT 3
`define QPU_AUTO_STEP_BIT 4
`define QPU_TOGGLE_BIT 5
`define QPU_DIR_EVEN_BIT 6
`define QPU_DIR_ODD_BIT 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define QPU_PTR_RESET 24'h000000
`define QPU_SELECT_RESET 8'h00
`define QPU_DIR_UPPER_RESET 8'h00

`endif

// File: src/qpu_pointer_unit.v
// qpu_pointer_unit.v: four 24-bit data pointers with select, direction,
// auto-toggle and auto-step logic.
// assumes the core decoder pulses at most one op strobe per cycle; a
// register write in the same cycle wins for the fields it writes.
`timescale 1ns/10ps
`include "qpu_regs.vh"

module qpu_pointer_unit (
    // clock and reset
    input wire clock_in,
    input wire rstn_in,
    // special register port
    input wire reg_wr_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    output reg [7:0] reg_rdata_out,
    output wire reg_hit_out,
    // instruction strobes from the decoder
    input wire op_ptr_inc_in,
    input wire op_load16_in,
    input wire op_load24_in,
    input wire [23:0] op_load_data_in,
    input wire op_code_table_read_in,
    input wire op_external_data_move_in,
    // active pointer to the address path
    output wire [23:0] active_pointer_out,
    output wire [1:0] active_index_out
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [23:0] ptr_q [0:3];
    reg [23:0] ptr_d [0:3];
    reg upper_sel_q;
    reg lower_sel_q;
    reg auto_step_q;
    reg toggle_q;
    reg [3:0] dir_q;
    reg upper_sel_d;
    reg lower_sel_d;
    reg auto_step_d;
    reg toggle_d;
    reg [3:0] dir_d;

    wire [1:0] act;
    assign act = {upper_sel_q, lower_sel_q};
    assign active_index_out = act;
    assign active_pointer_out = ptr_q[act];

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // returns {valid, pointer index, byte lane}; lane 0 low, 1 mid, 2 high
    function [4:0] ptr_decode;
        input [7:0] a;
        begin
            case (a)
                `QPU_PTR0_LOW_ADDR: ptr_decode = 5'h10;
                `QPU_PTR0_MID_ADDR: ptr_decode = 5'h11;
                `QPU_PTR0_HIGH_ADDR: ptr_decode = 5'h12;
                `QPU_PTR1_LOW_ADDR: ptr_decode = 5'h14;
                `QPU_PTR1_MID_ADDR: ptr_decode = 5'h15;
                `QPU_PTR1_HIGH_ADDR: ptr_decode = 5'h16;
                `QPU_PTR2_LOW_ADDR: ptr_decode = 5'h18;
                `QPU_PTR2_MID_ADDR: ptr_decode = 5'h19;
                `QPU_PTR2_HIGH_ADDR: ptr_decode = 5'h1a;
                `QPU_PTR3_LOW_ADDR: ptr_decode = 5'h1c;
                `QPU_PTR3_MID_ADDR: ptr_decode = 5'h1d;
                `QPU_PTR3_HIGH_ADDR: ptr_decode = 5'h1e;
                default: ptr_decode = 5'h00;
            endcase
        end
    endfunction

    wire [4:0] dec;
    assign dec = ptr_decode(reg_addr_in);
    wire sel_hit;
    wire dir_hit;
    assign sel_hit = (reg_addr_in == `QPU_SELECT_ADDR);
    assign dir_hit = (reg_addr_in == `QPU_DIR_UPPER_ADDR);
    assign reg_hit_out = dec[4] | sel_hit | dir_hit;

    // ----------------------------------------
    // operation decode
    // ----------------------------------------
    wire step_op;
    wire toggle_op;
    // auto step only after table reads and external moves
    assign step_op = op_ptr_inc_in
        | (auto_step_q & (op_code_table_read_in
        | op_external_data_move_in));
    assign toggle_op = toggle_q & (op_ptr_inc_in | op_load16_in
        | op_load24_in | op_code_table_read_in
        | op_external_data_move_in);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    integer i;
    always @* begin
        for (i = 0; i < 4; i = i + 1) begin
            ptr_d[i] = ptr_q[i];
        end
        upper_sel_d = upper_sel_q;
        lower_sel_d = lower_sel_q;
        auto_step_d = auto_step_q;
        toggle_d = toggle_q;
        dir_d = dir_q;
        // pointer update uses the selection valid before the op
        if (step_op) begin
            if (dir_q[act]) begin
                ptr_d[act] = ptr_q[act] - 24'h000001;
            end else begin
                ptr_d[act] = ptr_q[act] + 24'h000001;
            end
        end else if (op_load16_in) begin
            // 16-bit load leaves the high byte untouched
            ptr_d[act] = {ptr_q[act][23:16], op_load_data_in[15:0]};
        end else if (op_load24_in) begin
            ptr_d[act] = op_load_data_in;
        end
        if (toggle_op) begin
            lower_sel_d = ~lower_sel_q;
        end
        if (reg_wr_in) begin
            if (dec[4]) begin
                case (dec[1:0])
                    2'h0: ptr_d[dec[3:2]][7:0] = reg_wdata_in;
                    2'h1: ptr_d[dec[3:2]][15:8] = reg_wdata_in;
                    default: ptr_d[dec[3:2]][23:16] = reg_wdata_in;
                endcase
            end
            if (sel_hit) begin
                lower_sel_d = reg_wdata_in[`QPU_LOWER_SEL_BIT];
                upper_sel_d = reg_wdata_in[`QPU_UPPER_SEL_BIT];
                auto_step_d = reg_wdata_in[`QPU_AUTO_STEP_BIT];
                toggle_d = reg_wdata_in[`QPU_TOGGLE_BIT];
                dir_d[0] = reg_wdata_in[`QPU_DIR_EVEN_BIT];
                dir_d[1] = reg_wdata_in[`QPU_DIR_ODD_BIT];
            end
            if (dir_hit) begin
                dir_d[2] = reg_wdata_in[`QPU_DIR_EVEN_BIT];
                dir_d[3] = reg_wdata_in[`QPU_DIR_ODD_BIT];
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ptr
            always @(posedge clock_in) begin
                if (!rstn_in) begin
                    ptr_q[g] <= `QPU_PTR_RESET;
                end else begin
                    ptr_q[g] <= ptr_d[g];
                end
            end
        end
    endgenerate

    always @(posedge clock_in) begin
        if (!rstn_in) begin
            upper_sel_q <= 1'h0;
            lower_sel_q <= 1'h0;
            auto_step_q <= 1'h0;
            toggle_q <= 1'h0;
            dir_q <= 4'h0;
        end else begin
            upper_sel_q <= upper_sel_d;
            lower_sel_q <= lower_sel_d;
            auto_step_q <= auto_step_d;
            toggle_q <= toggle_d;
            dir_q <= dir_d;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // bits 1 and 2 of the select register read zero, so an
    // increment of the whole register only flips the lower select
    always @* begin
        reg_rdata_out = 8'h00;
        if (dec[4]) begin
            case (dec[1:0])
                2'h0: reg_rdata_out = ptr_q[dec[3:2]][7:0];
                2'h1: reg_rdata_out = ptr_q[dec[3:2]][15:8];
                default: reg_rdata_out = ptr_q[dec[3:2]][23:16];
            endcase
        end else if (sel_hit) begin
            reg_rdata_out = {dir_q[1], dir_q[0], toggle_q, auto_step_q,
                upper_sel_q, 3'h0} | {7'h00, lower_sel_q};
        end else if (dir_hit) begin
            reg_rdata_out = {dir_q[3], dir_q[2], 6'h00};
        end
    end

endmodule // qpu_pointer_unit

// File: dv/qpu_props.sv
// qpu_props.sv: port assertions for the quad pointer unit
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module qpu_props (
    // clock and register port
    input wire clock_in,
    input wire rstn_in,
    input wire reg_wr_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_rdata_out,
    input wire reg_hit_out,
    // strobes and pointer view
    input wire op_ptr_inc_in,
    input wire op_load16_in,
    input wire op_load24_in,
    input wire [23:0] op_load_data_in,
    input wire op_code_table_read_in,
    input wire op_external_data_move_in,
    input wire [23:0] active_pointer_out,
    input wire [1:0] active_index_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    wire any_op = op_ptr_inc_in | op_load16_in | op_load24_in |
        op_code_table_read_in | op_external_data_move_in;
    wire [23:0] ap = active_pointer_out;
    wire [1:0] ix = active_index_out;
    a_inc_one_step: assert property (
        op_ptr_inc_in && !reg_wr_in ##1 $stable(ix) |->
        ap == $past(ap) + 24'h1 || ap == $past(ap) - 24'h1)
        else $error("increment not a single step");
    a_upper_kept: assert property (any_op && !reg_wr_in |=>
        ix[1] == $past(ix[1])) else $error("upper select moved");
    a_lower_flip: assert property (
        any_op && !reg_wr_in ##1 $changed(ix) |-> ix == ($past(ix) ^ 2'h1))
        else $error("bad toggle");
    a_load24_value: assert property (
        op_load24_in && !reg_wr_in ##1 $stable(ix) |->
        ap == $past(op_load_data_in)) else $error("load24 wrong");
    a_load16_high: assert property (
        op_load16_in && !reg_wr_in ##1 $stable(ix) |->
        ap == {$past(ap[23:16]), $past(op_load_data_in[15:0])})
        else $error("load16 wrong");
    a_legacy_hit: assert property (
        reg_addr_in == 8'h82 || reg_addr_in == 8'h83 |-> reg_hit_out)
        else $error("legacy address unmapped");
    a_select_mirror: assert property (reg_addr_in == 8'h86 |->
        {reg_rdata_out[3], reg_rdata_out[0]} == ix) else $error("sel");
    a_select_gaps: assert property (reg_addr_in == 8'h86 |->
        reg_rdata_out[2:1] == 2'h0) else $error("gap bits set");
    c_toggle: cover property (any_op ##1 $changed(ix));
    c_wrap: cover property (op_ptr_inc_in ##1 ap == 24'h0);
    c_load24: cover property (op_load24_in);
endmodule // qpu_props

bind qpu_pointer_unit qpu_props chk_u (.clock_in(clock_in),
    .rstn_in(rstn_in), .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
    .reg_rdata_out(reg_rdata_out), .reg_hit_out(reg_hit_out),
    .op_ptr_inc_in(op_ptr_inc_in), .op_load16_in(op_load16_in),
    .op_load24_in(op_load24_in), .op_load_data_in(op_load_data_in),
    .op_code_table_read_in(op_code_table_read_in),
    .op_external_data_move_in(op_external_data_move_in),
    .active_pointer_out(active_pointer_out),
    .active_index_out(active_index_out));

// File: dv/qpu_core_model.sv
// qpu_core_model.sv: decoder stand-in issuing pointer instruction strobes
// assumes strobes are sampled on the rising edge of clock_in
`timescale 1ns/10ps
module qpu_core_model (
    input wire clock_in,
    output logic [4:0] op_out,
    output logic [23:0] data_out
);
    initial begin
        op_out = 5'h00;
        data_out = 24'h000000;
    end
    // kind: 0 inc, 1 load16, 2 load24, 3 table read, 4 external move
    task automatic issue(input int kind, input logic [23:0] val);
        @(negedge clock_in);
        op_out = 5'h01 << kind;
        data_out = val;
        @(negedge clock_in);
        op_out = 5'h00;
        data_out = ~val; // load value is not held past its cycle
    endtask
endmodule // qpu_core_model

// File: dv/testbench.sv
// testbench.sv: self-checking bench for the quad pointer unit
// assumes the core stand-in and the bound checker are compiled first
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %0t: got %h want %h", $time, g, e); end end
module testbench;
    logic clock_in = 0, rstn_in = 0, reg_wr_in = 0;
    logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
    wire [7:0] rdata;
    wire hit;
    wire [4:0] op;
    wire [23:0] ld, ptr;
    wire [1:0] idx;
    int n_checks = 0, n_mismatch = 0, cycles = 0, p;
    logic [7:0] addrs [14] = '{8'h93, 8'h83, 8'h82, 8'h95, 8'h85, 8'h84,
        8'heb, 8'hf3, 8'hf2, 8'hed, 8'hf5, 8'hf4, 8'h86, 8'he3};
    qpu_core_model core_u (.clock_in(clock_in), .op_out(op), .data_out(ld));
    qpu_pointer_unit dut_u (.clock_in(clock_in), .rstn_in(rstn_in),
        .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(rdata),
        .reg_hit_out(hit), .op_ptr_inc_in(op[0]), .op_load16_in(op[1]),
        .op_load24_in(op[2]), .op_load_data_in(ld),
        .op_code_table_read_in(op[3]), .op_external_data_move_in(op[4]),
        .active_pointer_out(ptr), .active_index_out(idx));
    initial forever #5 clock_in = ~clock_in;
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_in);
        reg_wr_in = 1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge clock_in);
        reg_wr_in = 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock_in);
        reg_addr_in = a;
        #1 `CHK(rdata, e)
    endtask
    task see(input logic [1:0] i, input logic [23:0] v);
        `CHK(idx, i)
        `CHK(ptr, v)
    endtask
    task t_reset;
        for (p = 0; p < 14; p++) rd(addrs[p], 8'h00);
        see(2'h0, 24'h000000);
        rd(8'h82, 8'h00);
        `CHK(hit, 1'h1)
    endtask
    task t_regs;
        for (p = 0; p < 12; p++) wr(addrs[p], 8'(p + 1));
        wr(8'h00, 8'h55);
        for (p = 0; p < 12; p++) rd(addrs[p], 8'(p + 1));
        rd(8'h00, 8'h00);
        `CHK(hit, 1'h0)
        for (p = 0; p < 4; p++) begin
            wr(8'h86, {4'h0, p[1], 2'h0, p[0]});
            see(2'(p), {8'(3*p+1), 8'(3*p+2), 8'(3*p+3)});
        end
        wr(8'h86, 8'hff);
        rd(8'h86, 8'hf9);
        wr(8'he3, 8'hff);
        rd(8'he3, 8'hc0);
    endtask
    task t_inc;
        wr(8'h86, 8'h00);
        for (p = 0; p < 3; p++) wr(addrs[p], 8'hff);
        core_u.issue(0, 24'h0);
        see(2'h0, 24'h000000);
        wr(8'h86, 8'h40);
        core_u.issue(0, 24'h0);
        see(2'h0, 24'hffffff);
        wr(8'h86, 8'h09);
        core_u.issue(0, 24'h0);
        see(2'h3, 24'h0a0b0b);
        wr(8'he3, 8'h40);
        core_u.issue(0, 24'h0);
        see(2'h3, 24'h0a0b0c);
    endtask
    task t_toggle;
        wr(8'h86, 8'h28);
        core_u.issue(2, 24'habcdef);
        see(2'h3, 24'h0a0b0c);
        core_u.issue(0, 24'h0);
        see(2'h2, 24'habcdef);
        rd(8'hf4, 8'h0d);
        core_u.issue(1, 24'h001234);
        see(2'h3, 24'h0a0b0d);
        core_u.issue(3, 24'h0);
        see(2'h2, 24'hab1234);
    endtask
    task t_auto;
        wr(8'h86, 8'h30);
        core_u.issue(4, 24'h0);
        see(2'h1, 24'h040506);
        core_u.issue(4, 24'h0);
        see(2'h0, 24'h000000);
        core_u.issue(3, 24'h0);
        see(2'h1, 24'h040507);
        rd(8'h82, 8'h01);
    endtask
    // loads with toggling off, so the active pointer stays put
    task t_load;
        wr(8'h86, 8'h00);
        core_u.issue(2, 24'h123456);
        see(2'h0, 24'h123456);
        core_u.issue(1, 24'h00abcd);
        see(2'h0, 24'h12abcd);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard well above the roughly 120 cycles the run needs
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            summarize;
        end
    end
    initial begin
        repeat (3) @(negedge clock_in);
        rstn_in = 1;
        t_reset;
        t_regs;
        t_inc;
        t_toggle;
        t_auto;
        t_load;
        summarize;
    end
endmodule // testbench
